// ===== rtl/agsc_agp_status_command_regs.sv
/*
 * agsc_agp_status_command_regs: AHB-Lite register bank holding the AGP
 * capability/status, operation/command and extra control registers, plus
 * the gate that admits AGP operations.
 * Assumes: single AHB-Lite slave, hsel_i qualifies the register window,
 * request strobes come from logic on sys_clk_i.
 */
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps

// Operation
// RULE1: status bits 31:24 report queue depth, default 1Fh, low six follow control.
// RULE2: queue depth setting accepts only 32, 16, 8, 4, 2 or 1.
// RULE3: status bit 9 always reads one, side band supported.
// RULE4: status bit 5 always reads zero, no above-4GB addressing.
// RULE5: status bit 4 always reads zero, no fast writes.
// RULE6: status rate bits 2:0 read 111 after reset: 1x, 2x, 4x.
// RULE7: status 4x bit is masked while the control override bit is set.
// RULE8: selected rate applies to both AD bus and side band bus.
// RULE9: command bit 9 enables side band addressing.
// RULE10: with command bit 8 clear every AGP operation, including sync, is ignored.
// RULE11: with bit 8 set pipe operations accepted; side band needs its enable too.
// RULE12: operations accepted while enabled complete after enable clears.
// RULE13: side band command arriving in 1x still issues if enable drops.
// RULE14: command bit 5 always reads zero.
// RULE15: software writes zero to command bit 4, fast write enable.
// RULE16: software sets exactly one rate bit, same in master and target.
// RULE17: software picks the rate after reading the master's capability.
// RULE18: under override, writes to command rate bit 2 have no effect.
// RULE19: reserved bits read zero and ignore writes.
module agsc_agp_status_command_regs (
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // AGP operation side
  input  wire logic        pipe_req_i,
  input  wire logic        pipe_done_i,
  input  wire logic        sync_req_i,
  input  wire logic        sba_start_i,
  input  wire logic        sba_end_i,
  output logic             pipe_accept_o,
  output logic             sync_accept_o,
  output logic             sba_issue_o,
  output logic             agp_busy_o,
  output logic      [2:0]  ad_rate_o,
  output logic      [2:0]  sba_rate_o,
  output logic             sba_enable_o,
  output logic             agp_enable_o
);

  // ---------------------------------------------------------------------------
  // decoding helpers
  // ---------------------------------------------------------------------------
  // depth code to request count minus one: 0=32 1=16 2=8 3=4 4=2 5=1
  function automatic logic [5:0] qdepth_value(input logic [2:0] code);
    logic [5:0] v;
    v = 6'h00;
    unique case (code)
      3'h0:    v = 6'h1f;
      3'h1:    v = 6'h0f;
      3'h2:    v = 6'h07;
      3'h3:    v = 6'h03;
      3'h4:    v = 6'h01;
      3'h5:    v = 6'h00;
      default: v = 6'h00;
    endcase
    return v;
  endfunction

  function automatic logic qdepth_legal(input logic [2:0] code);
    return code <= agsc_pkg::QDEPTH_CODE_MAX;
  endfunction

  // ---------------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------------
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] rdata_reg;
  logic        sba_en_reg;
  logic        agp_en_reg;
  logic        fw_en_reg;
  logic [2:0]  rate_reg;
  logic        override_reg;
  logic [2:0]  qdepth_code_reg;

  logic        addr_take;
  logic        wr_cmd;
  logic        wr_ctrl;
  logic [31:0] status_word;
  logic [31:0] command_word;
  logic [31:0] ctrl_word;
  logic [31:0] read_word;
  logic [2:0]  new_code;

  agsc_ctrl_if ctrl_bus ();

  // ---------------------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------------------
  // while frozen the bank stretches the data phase rather than drop a write
  assign hreadyout_o = ce_i;
  assign hresp_o     = 1'b0;
  assign addr_take   = ce_i & hready_i & hsel_i & htrans_i[1];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (ce_i) begin
      // partial-word writes are dropped; only whole words are defined
      wr_pend_reg <= addr_take & hwrite_i & (hsize_i == agsc_pkg::HSIZE_WORD);
      if (addr_take) begin
        wr_addr_reg <= haddr_i[7:0];
      end
    end
  end

  assign wr_cmd  = ce_i & wr_pend_reg & (wr_addr_reg == agsc_pkg::ADDR_COMMAND);
  assign wr_ctrl = ce_i & wr_pend_reg & (wr_addr_reg == agsc_pkg::ADDR_EXTRA_CTRL);

  // ---------------------------------------------------------------------------
  // read words
  // ---------------------------------------------------------------------------
  always_comb begin
    status_word = 32'h0000_0000; // RULE19
    status_word[agsc_pkg::STAT_RQ_LSB +: 6] = qdepth_value(qdepth_code_reg); // RULE1
    status_word[agsc_pkg::STAT_SBA_BIT]     = 1'b1;  // RULE3
    status_word[agsc_pkg::STAT_4G_BIT]      = 1'b0;  // RULE4
    status_word[agsc_pkg::STAT_FW_BIT]      = 1'b0;  // RULE5
    status_word[agsc_pkg::STAT_RATE_LSB +: 3] = {~override_reg, 2'b11}; // RULE6 RULE7
  end

  always_comb begin
    command_word = 32'h0000_0000; // RULE19
    command_word[agsc_pkg::CMD_SBA_EN_BIT]    = sba_en_reg;
    command_word[agsc_pkg::CMD_AGP_EN_BIT]    = agp_en_reg;
    command_word[agsc_pkg::CMD_4G_BIT]        = 1'b0; // RULE14
    command_word[agsc_pkg::CMD_FW_BIT]        = fw_en_reg;
    command_word[agsc_pkg::CMD_RATE_LSB +: 3] = rate_reg;
  end

  always_comb begin
    ctrl_word = 32'h0000_0000; // RULE19
    ctrl_word[agsc_pkg::CTRL_OVR_BIT]           = override_reg;
    ctrl_word[agsc_pkg::CTRL_QDEPTH_LSB +: 3]   = qdepth_code_reg;
  end

  always_comb begin
    unique case (haddr_i[7:0])
      agsc_pkg::ADDR_STATUS:     read_word = status_word;
      agsc_pkg::ADDR_COMMAND:    read_word = command_word;
      agsc_pkg::ADDR_EXTRA_CTRL: read_word = ctrl_word;
      default:                   read_word = 32'h0000_0000;
    endcase
  end

  // read data is captured with the address so the data phase waits only while ce_i is low
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce_i) begin
      if (addr_take && !hwrite_i) begin
        rdata_reg <= read_word;
      end
    end
  end

  assign hrdata_o = rdata_reg;

  // ---------------------------------------------------------------------------
  // command register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sba_en_reg <= agsc_pkg::COMMAND_RESET[agsc_pkg::CMD_SBA_EN_BIT];
      agp_en_reg <= agsc_pkg::COMMAND_RESET[agsc_pkg::CMD_AGP_EN_BIT];
      fw_en_reg  <= agsc_pkg::COMMAND_RESET[agsc_pkg::CMD_FW_BIT];
    end else if (wr_cmd) begin
      sba_en_reg <= hwdata_i[agsc_pkg::CMD_SBA_EN_BIT]; // RULE9
      agp_en_reg <= hwdata_i[agsc_pkg::CMD_AGP_EN_BIT]; // RULE10
      // kept only for readback; the gate never looks at it
      fw_en_reg  <= hwdata_i[agsc_pkg::CMD_FW_BIT];     // RULE15
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rate_reg <= agsc_pkg::COMMAND_RESET[agsc_pkg::CMD_RATE_LSB +: 3];
    end else if (wr_cmd) begin
      // rate is taken as written, bit 2 only while override is clear; exactly one bit is up to software
      rate_reg[1:0] <= hwdata_i[agsc_pkg::CMD_RATE_LSB +: 2]; // RULE16
      if (!override_reg) begin
        rate_reg[2] <= hwdata_i[agsc_pkg::CMD_RATE_LSB + 2];  // RULE18
      end
    end
  end

  // ---------------------------------------------------------------------------
  // extra control register
  // ---------------------------------------------------------------------------
  assign new_code = hwdata_i[agsc_pkg::CTRL_QDEPTH_LSB +: 3];

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      override_reg    <= agsc_pkg::CTRL_RESET[agsc_pkg::CTRL_OVR_BIT];
      qdepth_code_reg <= agsc_pkg::CTRL_RESET[agsc_pkg::CTRL_QDEPTH_LSB +: 3];
    end else if (wr_ctrl) begin
      override_reg <= hwdata_i[agsc_pkg::CTRL_OVR_BIT]; // RULE7
      // an undefined depth code leaves the previous depth in place
      if (qdepth_legal(new_code)) begin
        qdepth_code_reg <= new_code; // RULE2
      end
    end
  end

  // ---------------------------------------------------------------------------
  // settings out to the link logic and the gate
  // ---------------------------------------------------------------------------
  assign ctrl_bus.agp_enable = agp_en_reg;
  assign ctrl_bus.sba_enable = sba_en_reg;
  assign ctrl_bus.rate       = rate_reg;
  assign ctrl_bus.queue_max  = qdepth_value(qdepth_code_reg); // RULE1

  assign ad_rate_o    = rate_reg; // RULE8
  assign sba_rate_o   = rate_reg; // RULE8
  assign sba_enable_o = sba_en_reg;
  assign agp_enable_o = agp_en_reg;

  agsc_op_gate u_gate (
    .sys_clk_i     (sys_clk_i),
    .resetn_i      (resetn_i),
    .ce_i          (ce_i),
    .ctrl          (ctrl_bus),
    .pipe_req_i    (pipe_req_i),
    .pipe_done_i   (pipe_done_i),
    .sync_req_i    (sync_req_i),
    .sba_start_i   (sba_start_i),
    .sba_end_i     (sba_end_i),
    .pipe_accept_o (pipe_accept_o),
    .sync_accept_o (sync_accept_o),
    .sba_issue_o   (sba_issue_o),
    .busy_o        (agp_busy_o)
  );

endmodule // agsc_agp_status_command_regs

// ===== rtl/agsc_ctrl_if.sv
/*
 * agsc_ctrl_if: settings that the register bank hands to the operation gate.
 * Assumes: both ends share sys_clk_i.
 */
`timescale 1ns/1ps
interface agsc_ctrl_if;
  logic       agp_enable;
  logic       sba_enable;
  logic [2:0] rate;
  logic [5:0] queue_max;

  modport regs (output agp_enable, output sba_enable, output rate, output queue_max);
  modport gate (input agp_enable, input sba_enable, input rate, input queue_max);
endinterface : agsc_ctrl_if

// ===== rtl/agsc_op_gate.sv
/*
 * agsc_op_gate: admits AGP operations according to the command register.
 * Assumes: request strobes come from logic on sys_clk_i, one cycle each.
 */
`timescale 1ns/1ps
module agsc_op_gate (
  input  wire logic   sys_clk_i,
  input  wire logic   resetn_i,
  input  wire logic   ce_i,
  agsc_ctrl_if.gate   ctrl,
  input  wire logic   pipe_req_i,
  input  wire logic   pipe_done_i,
  input  wire logic   sync_req_i,
  input  wire logic   sba_start_i,
  input  wire logic   sba_end_i,
  output logic        pipe_accept_o,
  output logic        sync_accept_o,
  output logic        sba_issue_o,
  output logic        busy_o
);

  logic [6:0] outstanding_reg;
  logic       sba_active_reg;
  logic       sba_take;
  logic       done_take;

  // ---------------------------------------------------------------------------
  // admission
  // ---------------------------------------------------------------------------
  // queue full stalls new requests; the limit follows the programmed depth
  assign pipe_accept_o = ce_i & pipe_req_i & ctrl.agp_enable &
                         (outstanding_reg <= {1'b0, ctrl.queue_max}); // RULE10 RULE11
  assign sync_accept_o = ce_i & sync_req_i & ctrl.agp_enable;         // RULE10
  assign sba_take      = sba_start_i & ctrl.agp_enable & ctrl.sba_enable; // RULE11
  assign done_take     = pipe_done_i & (outstanding_reg != 7'h00);
  // a command already started still issues after enable drops only at 1x; at any other rate the drop cancels it
  assign sba_issue_o   = ce_i & sba_end_i & (sba_active_reg | sba_take); // RULE13
  assign busy_o        = (outstanding_reg != 7'h00) | sba_active_reg;

  // ---------------------------------------------------------------------------
  // outstanding queued operations keep completing after enable clears
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outstanding_reg <= 7'h00;
    end else if (ce_i) begin
      outstanding_reg <= outstanding_reg + {6'h00, pipe_accept_o}
                         - {6'h00, done_take}; // RULE12
    end
  end

  // ---------------------------------------------------------------------------
  // side band command in flight
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sba_active_reg <= 1'b0;
    end else if (ce_i) begin
      if (sba_end_i) begin
        sba_active_reg <= 1'b0;
      end else if (sba_take) begin
        sba_active_reg <= 1'b1;
      end else if (!ctrl.agp_enable && (ctrl.rate != agsc_pkg::RATE_1X)) begin
        // only 1x delivery is carried through a drop of enable
        sba_active_reg <= 1'b0; // RULE13
      end
    end
  end

endmodule // agsc_op_gate

// ===== rtl/agsc_pkg.sv
/*
 * agsc_pkg: register offsets, field positions and reset values of the AGP
 * capability/status and operation/command register pair.
 * Assumes: the register bank decodes the low byte of the AHB-Lite address.
 */
package agsc_pkg;

  // ---------------------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  ADDR_STATUS      = 8'ha4;
  localparam logic [7:0]  ADDR_COMMAND     = 8'ha8;
  localparam logic [7:0]  ADDR_EXTRA_CTRL  = 8'hac;

  // ---------------------------------------------------------------------------
  // agp_capability_status fields
  // ---------------------------------------------------------------------------
  localparam int          STAT_RQ_LSB      = 24;
  localparam int          STAT_SBA_BIT     = 9;
  localparam int          STAT_4G_BIT      = 5;
  localparam int          STAT_FW_BIT      = 4;
  localparam int          STAT_RATE_LSB    = 0;
  localparam logic [31:0] STATUS_RESET     = 32'h1f00_0207;

  // ---------------------------------------------------------------------------
  // agp_operation_command fields
  // ---------------------------------------------------------------------------
  localparam int          CMD_SBA_EN_BIT   = 9;
  localparam int          CMD_AGP_EN_BIT   = 8;
  localparam int          CMD_4G_BIT       = 5;
  localparam int          CMD_FW_BIT       = 4;
  localparam int          CMD_RATE_LSB     = 0;
  localparam logic [31:0] COMMAND_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // agp_extra_control fields
  // ---------------------------------------------------------------------------
  localparam int          CTRL_OVR_BIT     = 0;
  localparam int          CTRL_QDEPTH_LSB  = 10;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------------------
  localparam logic [2:0]  RATE_1X          = 3'h1;
  localparam logic [2:0]  RATE_2X          = 3'h2;
  localparam logic [2:0]  RATE_4X          = 3'h4;
  localparam logic [2:0]  QDEPTH_CODE_MAX  = 3'h5;
  localparam logic [5:0]  QDEPTH_RESET     = 6'h1f;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;

endpackage : agsc_pkg

// ===== verif/agsc_agp_master_model.sv
/*
 * agsc_agp_master_model: behavioural AGP master raising one-cycle operation strobes.
 * Assumes: callers enter its tasks just after a rising edge of sys_clk_i.
 */
`timescale 1ns/1ps
module agsc_agp_master_model (
  input  wire logic sys_clk_i,
  input  wire logic pipe_accept_i,
  input  wire logic sync_accept_i,
  input  wire logic sba_issue_i,
  output logic      pipe_req_o,
  output logic      pipe_done_o,
  output logic      sync_req_o,
  output logic      sba_start_o,
  output logic      sba_end_o
);
  initial {pipe_req_o, pipe_done_o, sync_req_o, sba_start_o, sba_end_o} = 5'h00;
  // kind 0 pipe request, 1 completion, 2 sync; answer taken at the strobe's edge
  task automatic op(input int k, output logic acc);
    pipe_req_o <= (k == 0);
    pipe_done_o <= (k == 1);
    sync_req_o <= (k == 2);
    @(posedge sys_clk_i);
    acc = (k == 0) ? pipe_accept_i : sync_accept_i;
    {pipe_req_o, pipe_done_o, sync_req_o} <= 3'h0;
    @(posedge sys_clk_i);
  endtask
  // start always precedes end; gap sets how slowly the command arrives
  task automatic sba(input int gap, output logic acc);
    sba_start_o <= 1'b1;
    @(posedge sys_clk_i);
    sba_start_o <= 1'b0;
    repeat (gap) @(posedge sys_clk_i);
    sba_end_o <= 1'b1;
    @(posedge sys_clk_i);
    acc = sba_issue_i;
    sba_end_o <= 1'b0;
    @(posedge sys_clk_i);
  endtask
endmodule // agsc_agp_master_model

// ===== verif/agsc_regs_monitor.sv
/*
 * agsc_regs_monitor: concurrent checks on the ports of the AGP status/command bank.
 * Assumes: one clock domain, hready_i tied to hreadyout_o, bound by name below.
 */
`timescale 1ns/1ps
module agsc_regs_monitor (
  input wire logic        sys_clk_i,
  input wire logic        resetn_i,
  input wire logic        ce_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [2:0]  hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        pipe_req_i,
  input wire logic        pipe_done_i,
  input wire logic        sync_req_i,
  input wire logic        sba_end_i,
  input wire logic        pipe_accept_o,
  input wire logic        sync_accept_o,
  input wire logic        sba_issue_o,
  input wire logic        agp_busy_o,
  input wire logic [2:0]  ad_rate_o,
  input wire logic [2:0]  sba_rate_o,
  input wire logic        sba_enable_o,
  input wire logic        agp_enable_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);
  // ---------------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------------
  logic       taken;
  logic [1:0] en_wd;
  logic [6:0] pend_reg;
  assign taken = ce_i && hready_i && hsel_i && htrans_i[1];
  assign en_wd = hwdata_i[9:8];
  // done strobes only count while something is outstanding, as the bank does
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pend_reg <= 7'h00;
    end else if (ce_i) begin
      pend_reg <= pend_reg + 7'(pipe_accept_o) - 7'(pipe_done_i && pend_reg != 7'h00);
    end
  end
  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  AST_SYNC_GATE: assert property (sync_accept_o == (ce_i && sync_req_i && agp_enable_o))
    else $error("sync accept does not follow request and enable");
  AST_PIPE_GATE: assert property (pipe_accept_o |-> pipe_req_i && agp_enable_o)
    else $error("pipe accepted without request or enable");
  AST_SBA_ISSUE: assert property (sba_issue_o |-> sba_end_i)
    else $error("side band issue without command end");
  AST_RATE_BOTH: assert property (ad_rate_o == sba_rate_o)
    else $error("data and side band rates differ");
  AST_NO_WAIT: assert property (hreadyout_o == ce_i && !hresp_o)
    else $error("bus wait or error response");
  AST_STATUS_FIXED: assert property (taken && !hwrite_i && haddr_i[7:0] == 8'ha4
    |=> (hrdata_o & 32'hc0ff_fff8) == 32'h0000_0200) else $error("status fixed bits wrong");
  AST_CMD_FIXED: assert property (taken && !hwrite_i && haddr_i[7:0] == 8'ha8
    |=> (hrdata_o & 32'hffff_fce8) == 32'h0000_0000) else $error("command fixed bits wrong");
  AST_ENABLES_WRITE: assert property (taken && hwrite_i && hsize_i == 3'h2
    && haddr_i[7:0] == 8'ha8 ##1 ce_i |=> {sba_enable_o, agp_enable_o} == $past(en_wd))
    else $error("enables do not follow command write");
  AST_BUSY_PENDING: assert property (pend_reg != 7'h00 |-> agp_busy_o)
    else $error("busy low with pipe operations outstanding");
  COV_SBA_LATE: cover property (sba_issue_o && !agp_enable_o);
  COV_PIPE_FULL: cover property (pipe_req_i && agp_enable_o && !pipe_accept_o);
  COV_SYNC: cover property (sync_accept_o);
endmodule // agsc_regs_monitor

bind agsc_agp_status_command_regs agsc_regs_monitor i_monitor (.*);

// ===== verif/tb_agsc_agp_status_command_regs.sv
/*
 * tb_agsc_agp_status_command_regs: directed register and operation tests.
 * Assumes: the bank answers with zero wait states while ce_i is high.
 */
`timescale 1ns/1ps
module tb_agsc_agp_status_command_regs;
  logic        sys_clk_i = 1'b0;
  logic        resetn_i  = 1'b0;
  logic        ce_i      = 1'b1;
  logic        hsel_i    = 1'b0;
  logic [31:0] haddr_i   = 32'h0000_0000;
  logic [1:0]  htrans_i  = 2'h0;
  logic        hwrite_i  = 1'b0;
  logic [2:0]  hsize_i   = 3'h2;
  logic [31:0] hwdata_i  = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic [2:0]  ad_rate_o, sba_rate_o;
  logic        hreadyout_o, hresp_o, pipe_req_i, pipe_done_i, sync_req_i, sba_start_i;
  logic        sba_end_i, pipe_accept_o, sync_accept_o, sba_issue_o, agp_busy_o;
  logic        sba_enable_o, agp_enable_o;
  int          num_errors = 0;
  int          total_checks = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  agsc_agp_status_command_regs i_dut (.hready_i(hreadyout_o), .*);
  agsc_agp_master_model i_agp (
    .sys_clk_i    (sys_clk_i),
    .pipe_accept_i(pipe_accept_o),
    .sync_accept_i(sync_accept_o),
    .sba_issue_i  (sba_issue_o),
    .pipe_req_o   (pipe_req_i),
    .pipe_done_o  (pipe_done_i),
    .sync_req_o   (sync_req_i),
    .sba_start_o  (sba_start_i),
    .sba_end_o    (sba_end_i)
  );
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for hready; running out ends the run as a mismatch
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (hreadyout_o !== 1'b1 && n < 16);
    if (hreadyout_o !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_i <= 1'b1;
    htrans_i <= agsc_pkg::HTRANS_NONSEQ;
    haddr_i <= {24'h00_0000, a};
    hwrite_i <= w;
    wait_ready();
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    wait_ready();
    rd = hrdata_o;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    check(x, exp);
  endtask
  task automatic op_chk(input int k, input logic exp);
    logic a;
    i_agp.op(k, a);
    check({31'h0000_0000, a}, {31'h0000_0000, exp});
  endtask
  task automatic sba_chk(input int gap, input logic exp);
    logic a;
    i_agp.sba(gap, a);
    check({31'h0000_0000, a}, {31'h0000_0000, exp});
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic a;
    int   c;
    repeat (2) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_chk(agsc_pkg::ADDR_STATUS, 32'h1f00_0207);
    rd_chk(agsc_pkg::ADDR_COMMAND, 32'h0000_0000);
    rd_chk(agsc_pkg::ADDR_EXTRA_CTRL, 32'h0000_0000);
    op_chk(0, 1'b0);
    op_chk(2, 1'b0);
    $display("test reset_and_disabled done");
    wr(agsc_pkg::ADDR_COMMAND, 32'hffff_ffe9);
    rd_chk(agsc_pkg::ADDR_COMMAND, 32'h0000_0301);
    check({29'h0000_0000, ad_rate_o}, 32'h0000_0001);
    check({29'h0000_0000, sba_rate_o}, 32'h0000_0001);
    wr(8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0000_0000);
    op_chk(2, 1'b1);
    sba_chk(0, 1'b1);
    sba_chk(3, 1'b1);
    $display("test command_fields done");
    for (c = 0; c < 32; c++) begin
      op_chk(0, 1'b1);
    end
    op_chk(0, 1'b0);
    for (c = 0; c < 32; c++) begin
      i_agp.op(1, a);
    end
    check({31'h0000_0000, agp_busy_o}, 32'h0000_0000);
    $display("test queue_full done");
    for (c = 0; c < 6; c++) begin
      wr(agsc_pkg::ADDR_EXTRA_CTRL, 32'(c) << 10);
      rd_chk(agsc_pkg::ADDR_STATUS, (((32'h0000_0020 >> c) - 32'h0000_0001) << 24) | 32'h0000_0207);
    end
    wr(agsc_pkg::ADDR_EXTRA_CTRL, 32'h0000_1800);
    rd_chk(agsc_pkg::ADDR_STATUS, 32'h0000_0207);
    op_chk(0, 1'b1);
    op_chk(0, 1'b0);
    $display("test queue_depth done");
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0201);
    check({31'h0000_0000, agp_busy_o}, 32'h0000_0001);
    op_chk(0, 1'b0);
    op_chk(2, 1'b0);
    sba_chk(0, 1'b0);
    i_agp.op(1, a);
    check({31'h0000_0000, agp_busy_o}, 32'h0000_0000);
    $display("test disable_drain done");
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0301);
    fork
      sba_chk(6, 1'b1);
      wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0201);
    join
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0101);
    sba_chk(0, 1'b0);
    // above 1x an enable drop in mid command cancels it
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0302);
    fork
      sba_chk(6, 1'b0);
      wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0202);
    join
    $display("test side_band done");
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0104);
    wr(agsc_pkg::ADDR_EXTRA_CTRL, 32'h0000_0001);
    rd_chk(agsc_pkg::ADDR_STATUS, 32'h1f00_0203);
    wr(agsc_pkg::ADDR_COMMAND, 32'h0000_0102);
    rd_chk(agsc_pkg::ADDR_COMMAND, 32'h0000_0106);
    check({29'h0000_0000, sba_rate_o}, 32'h0000_0006);
    $display("test quad_override done");
    // a frozen bank neither accepts nor counts a request
    ce_i <= 1'b0;
    op_chk(0, 1'b0);
    ce_i <= 1'b1;
    check({31'h0000_0000, agp_busy_o}, 32'h0000_0000);
    op_chk(0, 1'b1);
    check({31'h0000_0000, agp_busy_o}, 32'h0000_0001);
    $display("test clock_enable done");
    tally_and_finish();
  end
endmodule // tb_agsc_agp_status_command_regs
